// ### rtl/drc_defines.vh
// Constants for the level-change and miscellaneous control block
`ifndef DRC_DEFINES_VH
`define DRC_DEFINES_VH
// Register offsets
`define DRC_OFF_RAMP 8'h07
`define DRC_OFF_MISC 8'h08
`define DRC_OFF_DET 8'h09
// Reset values
`define DRC_RST_RAMP 8'hB0
`define DRC_RST_MISC 8'h80
`define DRC_RST_DET 8'h08
// Writable-bit masks, reserved bits stay zero
`define DRC_MSK_RAMP 8'hF5
`define DRC_MSK_MISC 8'hF8
`define DRC_MSK_DET 8'h0F
// Ramp and filter control fields
`define DRC_POL_HI 7
`define DRC_POL_LO 6
`define DRC_RAMP_UP 5
`define DRC_RAMP_DN 4
`define DRC_ROLLOFF 2
`define DRC_DIRECT 0
// Misc control fields
`define DRC_PWR_DN 7
`define DRC_REG_MODE 6
`define DRC_FREEZE 5
`define DRC_CLK_HALF 4
`define DRC_CLK_THIRD 3
// Bitstream detect fields
`define DRC_STATIC_DET 3
`define DRC_INVALID_DET 2
`define DRC_PM_CLKSEL 1
`define DRC_PM_EN 0
// Level in 1/8 dB units; full attenuation is code 255 times four
`define DRC_LVL_MAX 10'h3FC
// Zero-cross timeout in sample periods, inside the 512..1024 window
`define DRC_ZC_TMO 10'h300
// Bitstream clocks per 1/8 dB step: 512/8 and 1024/8
`define DRC_BS_STEP 8'h3F
`define DRC_BS_STEP_PM 8'h7F
// Static run length and invalid-window limit
`define DRC_STATIC_RUN 5'h1C
`define DRC_WIN_LEN 28
`define DRC_INVALID_LIM 5'h18
// Frames during which conversion is held for a coefficient reload
`define DRC_RELOAD_FRAMES 5'h10
`endif

// ### rtl/drc_ramp_ctrl.v
// Level-change policy engine, filter/error mute sequencing and control registers
// Functional notes
// - Two-bit policy picks immediate, zero-cross, ramp, ramp-on-zero-cross; bitstream only immediate/ramp.
// - Immediate policy jumps straight to the requested level.
// - Zero-cross policy waits for the channel's signal to cross zero.
// - Without a crossing, the change is forced after 512 to 1024 samples.
// - Crossing detection and timeout are kept separately per channel.
// - Sample ramp steps 1/8 dB each frame, 1 dB per 8 frames.
// - Bitstream ramp takes 1 dB per 512 clocks, 1024 with 128x clock.
// - Ramp on zero crossings applies each 1/8 dB step at a crossing or timeout.
// - After clock error or mode change unmute, by policy if ramp-up set.
// - Rolloff or de-emphasis change suspends conversion to reload coefficients.
// - Ramp-down bit mutes and unmutes by policy; cleared mutes immediately.
// - Rolloff select 0 is fast, default; 1 is slow.
// - Direct path bypasses the bitstream processor and volume control.
// - Power down, set by default, honoured only in register mode.
// - Register-mode enable defaults 0, stand-alone; 1 gives registers control.
// - Freeze holds written values; clearing it applies them all at once.
// - Halve bit divides the master clock by two for all processing; register access stays on the full clock.
// - Third bit divides the master clock by three for all processing; register access stays on the full clock.
// - Static detect mutes after 28 identical bits; mute follows auto-mute.
// - Invalid detect attenuates when over 24 of 28 bits match.
// - Phase-modulation enable switches bitstream input to phase-modulated mode.
// - Channel mute follows the policy; mute output asserts after ramp completes.
// - Eight-bit attenuation code gives 1/2 dB steps, the ramp target.
`include "drc_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module drc_ramp_ctrl (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire [15:0] attenuation_code_i,
  input wire [1:0] chan_mute_i,
  input wire [1:0] deemphasis_select_i,
  input wire bitstream_mode_i,
  input wire ratio_error_i,
  input wire frame_clock_i,
  input wire bitstream_serial_clock_i,
  input wire [1:0] bitstream_bit_i,
  input wire bitstream_auto_mute_i,
  input wire smp_valid_i,
  output wire smp_ready_o,
  input wire [47:0] smp_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [47:0] out_data_o,
  output reg [19:0] gain_level_o,
  output wire [1:0] mute_control_out_o,
  output wire [1:0] bitstream_atten_o,
  output reg conv_suspend_o,
  output wire interp_rolloff_select_o,
  output wire direct_bitstream_path_o,
  output wire phase_mod_enable_o,
  output wire phase_mod_clock_select_o,
  output wire power_down_o,
  output wire register_mode_enable_o,
  output reg clk_en_o
);
  localparam F_IDLE = 2'h0;
  localparam F_DOWN = 2'h1;
  localparam F_LOAD = 2'h2;

  reg [7:0] sh_ramp, sh_misc, sh_det;
  reg [7:0] ac_ramp, ac_misc, ac_det;
  reg [1:0] div_cnt, div_top;
  reg [1:0] fstate;
  reg [4:0] load_cnt;
  reg force_mute, imm_ovr, jump_max, prev_roll, prev_mode;
  reg [1:0] prev_dem;
  reg [7:0] bs_cnt;
  reg [47:0] buf0, buf1;
  reg [1:0] buf_cnt;
  wire ce, bs_mode, bs_tick, smp_take, out_take, filt_chg;
  wire [1:0] pol, at_max, at_tgt, zc_evt, stat_det, inv_det;

  // Control port writes always land in the shadow copy
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_ramp <= `DRC_RST_RAMP;
      sh_misc <= `DRC_RST_MISC;
      sh_det <= `DRC_RST_DET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `DRC_OFF_RAMP: sh_ramp <= reg_wdata_i & `DRC_MSK_RAMP;
        `DRC_OFF_MISC: sh_misc <= reg_wdata_i & `DRC_MSK_MISC;
        `DRC_OFF_DET: sh_det <= reg_wdata_i & `DRC_MSK_DET;
        default: ;
      endcase
    end
  end

  // Active copy tracks the shadow unless frozen; release applies all at once
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ac_ramp <= `DRC_RST_RAMP;
      ac_misc <= `DRC_RST_MISC;
      ac_det <= `DRC_RST_DET;
    end else if (!sh_misc[`DRC_FREEZE]) begin
      ac_ramp <= sh_ramp;
      ac_misc <= sh_misc;
      ac_det <= sh_det;
    end
  end

  // Read back shows what software wrote, reserved bits zero
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        `DRC_OFF_RAMP: reg_rdata_o <= sh_ramp;
        `DRC_OFF_MISC: reg_rdata_o <= sh_misc;
        `DRC_OFF_DET: reg_rdata_o <= sh_det;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  assign register_mode_enable_o = ac_misc[`DRC_REG_MODE];
  assign power_down_o = ac_misc[`DRC_REG_MODE] & ac_misc[`DRC_PWR_DN];
  assign interp_rolloff_select_o = ac_ramp[`DRC_ROLLOFF];
  assign direct_bitstream_path_o = ac_ramp[`DRC_DIRECT] & bitstream_mode_i;
  assign phase_mod_enable_o = ac_det[`DRC_PM_EN];
  assign phase_mod_clock_select_o = ac_det[`DRC_PM_CLKSEL];

  // Master clock divider; both bits together give divide by six via two stages
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 2'h0;
      div_top <= 2'h0;
      clk_en_o <= 1'b0;
    end else begin
      if (ac_misc[`DRC_CLK_THIRD] && div_cnt != 2'h2) begin
        div_cnt <= div_cnt + 2'h1;
        clk_en_o <= 1'b0;
      end else begin
        div_cnt <= 2'h0;
        div_top <= div_top + 2'h1;
        clk_en_o <= !ac_misc[`DRC_CLK_HALF] | div_top[0];
      end
    end
  end

  // Sample intake and level processing stall in power down; registers stay reachable and buffered words still drain
  assign ce = clk_en_o & !power_down_o;
  assign bs_mode = bitstream_mode_i;
  // Bitstream input knows only immediate and ramp
  assign pol = bs_mode ? {ac_ramp[`DRC_POL_HI], 1'b0} : ac_ramp[`DRC_POL_HI:`DRC_POL_LO];

  // Bitstream ramp pacing, 8 steps per 1 dB
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bs_cnt <= 8'h00;
    end else if (ce && bitstream_serial_clock_i) begin
      if (bs_tick) begin
        bs_cnt <= 8'h00;
      end else begin
        bs_cnt <= bs_cnt + 8'h01;
      end
    end
  end
  // Fast 128x clock in phase-modulated mode needs twice the count
  assign bs_tick = (ac_det[`DRC_PM_EN] && !ac_det[`DRC_PM_CLKSEL]) ? (bs_cnt == `DRC_BS_STEP_PM) :
    (bs_cnt == `DRC_BS_STEP);

  // Two-entry buffer so a stalled receiver loses no sample
  assign smp_ready_o = (buf_cnt != 2'h2) & ce;
  assign smp_take = smp_valid_i & smp_ready_o;
  assign out_valid_o = buf_cnt != 2'h0;
  assign out_take = out_valid_o & out_ready_i;
  assign out_data_o = buf0;
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf0 <= 48'h0;
      buf1 <= 48'h0;
      buf_cnt <= 2'h0;
    end else begin
      if (out_take) begin
        buf0 <= (buf_cnt == 2'h2) ? buf1 : smp_data_i;
      end else if (smp_take && buf_cnt == 2'h0) begin
        buf0 <= smp_data_i;
      end
      if (smp_take && ((buf_cnt == 2'h1 && !out_take) || buf_cnt == 2'h2)) begin
        buf1 <= smp_data_i;
      end
      buf_cnt <= buf_cnt + {1'b0, smp_take} - {1'b0, out_take};
    end
  end

  // Filter change detection and mute sequencing
  assign filt_chg = (prev_roll != ac_ramp[`DRC_ROLLOFF]) || (prev_dem != deemphasis_select_i);
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fstate <= F_IDLE;
      load_cnt <= 5'h00;
      force_mute <= 1'b0;
      imm_ovr <= 1'b0;
      jump_max <= 1'b0;
      prev_roll <= 1'b0;
      prev_dem <= 2'h0;
      prev_mode <= 1'b0;
      conv_suspend_o <= 1'b0;
    end else if (ce) begin
      jump_max <= 1'b0;
      prev_mode <= bs_mode;
      if (imm_ovr && !jump_max && at_tgt == 2'h3) begin // Old level may equal target before the jump
        imm_ovr <= 1'b0;
      end
      // Clock error or mode change drops to mute, then unmutes
      if (ratio_error_i || prev_mode != bs_mode) begin
        jump_max <= 1'b1;
        imm_ovr <= !ac_ramp[`DRC_RAMP_UP];
      end
      case (fstate)
        F_IDLE: begin
          if (filt_chg) begin
            prev_roll <= ac_ramp[`DRC_ROLLOFF];
            prev_dem <= deemphasis_select_i;
            if (ac_ramp[`DRC_RAMP_DN]) begin
              force_mute <= 1'b1;
              fstate <= F_DOWN;
            end else begin
              jump_max <= 1'b1;
              force_mute <= 1'b1;
              fstate <= F_LOAD;
            end
          end
        end
        F_DOWN: begin
          // Coefficients only swap once both channels are silent
          if (at_max == 2'h3) begin
            fstate <= F_LOAD;
          end
        end
        F_LOAD: begin
          conv_suspend_o <= 1'b1;
          if (frame_clock_i) begin
            load_cnt <= load_cnt + 5'h01;
          end
          if (load_cnt == `DRC_RELOAD_FRAMES) begin
            load_cnt <= 5'h00;
            conv_suspend_o <= 1'b0;
            force_mute <= 1'b0;
            imm_ovr <= !ac_ramp[`DRC_RAMP_DN];
            fstate <= F_IDLE;
          end
        end
        default: fstate <= F_IDLE;
      endcase
    end
  end

  // Per-channel level engine
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      reg [9:0] level;
      reg [9:0] tmo;
      reg last_sign;
      reg [4:0] run;
      reg [4:0] ones;
      reg [`DRC_WIN_LEN-1:0] win;
      reg stat_hit;
      reg inv_hit;
      wire [9:0] target;
      wire zc_ok;
      wire tick;
      wire step_en;
      wire [23:0] smp;
      wire bit_now;
      wire [4:0] ones_nx;
      assign smp = smp_data_i[24*ch+23:24*ch];
      // Mute request means full attenuation; code steps of 1/2 dB are four 1/8 dB units
      assign target = (chan_mute_i[ch] | force_mute) ? `DRC_LVL_MAX :
        {attenuation_code_i[8*ch+7:8*ch], 2'b00};
      assign at_tgt[ch] = level == target;
      assign at_max[ch] = level == `DRC_LVL_MAX;
      // Crossing: sign flips between samples or a zero sample
      assign zc_evt[ch] = smp_take && (smp[23] != last_sign || smp == 24'h0);
      assign zc_ok = zc_evt[ch] || tmo == `DRC_ZC_TMO;
      assign tick = bs_mode ? (bitstream_serial_clock_i & bs_tick) : frame_clock_i;
      assign step_en = (pol == 2'h2) ? tick : zc_ok;
      always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          level <= 10'h000;
          tmo <= 10'h000;
          last_sign <= 1'b0;
        end else if (ce) begin
          if (smp_take) begin
            last_sign <= smp[23];
          end
          // Timeout counts sample periods only while a change is pending
          if (at_tgt[ch] || zc_ok) begin
            tmo <= 10'h000;
          end else if (frame_clock_i) begin
            tmo <= tmo + 10'h001;
          end
          if (jump_max) begin
            level <= `DRC_LVL_MAX;
          end else if (imm_ovr || direct_bitstream_path_o || pol == 2'h0) begin
            level <= target;
          end else if (pol == 2'h1) begin
            if (zc_ok) begin
              level <= target;
            end
          end else if (step_en && !at_tgt[ch]) begin
            // Single 1/8 dB step, direction re-evaluated every step
            level <= (level < target) ? level + 10'h001 : level - 10'h001;
          end
        end
      end
      // Bitstream watchdogs: run length and sliding-window majority
      assign bit_now = bitstream_bit_i[ch];
      assign ones_nx = ones + {4'h0, bit_now} - {4'h0, win[`DRC_WIN_LEN-1]};
      always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          run <= 5'h00;
          ones <= 5'h00;
          win <= {`DRC_WIN_LEN{1'b0}};
          stat_hit <= 1'b0;
          inv_hit <= 1'b0;
        end else if (ce && bitstream_serial_clock_i && bs_mode) begin
          win <= {win[`DRC_WIN_LEN-2:0], bit_now};
          ones <= ones_nx;
          if (bit_now != win[0]) begin
            run <= 5'h01;
          end else if (run != `DRC_STATIC_RUN) begin
            run <= run + 5'h01;
          end
          stat_hit <= ac_det[`DRC_STATIC_DET] && bit_now == win[0] &&
            run >= `DRC_STATIC_RUN - 5'h01;
          inv_hit <= ac_det[`DRC_INVALID_DET] && (ones_nx > `DRC_INVALID_LIM ||
            ones_nx < `DRC_STATIC_RUN - `DRC_INVALID_LIM);
        end
      end
      assign stat_det[ch] = stat_hit & bs_mode;
      assign inv_det[ch] = inv_hit & bs_mode;
      // Mute pin for a channel mute only once the level has arrived at silence; auto-muted watchdog hits assert it at once
      assign mute_control_out_o[ch] = (chan_mute_i[ch] & at_max[ch]) |
        (bitstream_auto_mute_i & (stat_det[ch] | inv_det[ch]));
      assign bitstream_atten_o[ch] = stat_det[ch] | inv_det[ch];
    end
  endgenerate

  // Gain outputs registered; direct path shows unity since volume is bypassed
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gain_level_o <= 20'h00000;
    end else if (direct_bitstream_path_o) begin
      gain_level_o <= 20'h00000;
    end else begin
      gain_level_o <= {g_chan[1].level, g_chan[0].level};
    end
  end
endmodule // drc_ramp_ctrl
`default_nettype wire

// ### testbench/drc_ramp_ctrl_properties.sv
// Concurrent checks on the ports of the control block
`timescale 1ns/10ps
`default_nettype none
module drc_ramp_ctrl_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [19:0] gain_level_o,
  input wire logic [1:0] mute_control_out_o,
  input wire logic [1:0] bitstream_atten_o,
  input wire logic direct_bitstream_path_o,
  input wire logic smp_ready_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [47:0] out_data_o,
  input wire logic power_down_o,
  input wire logic register_mode_enable_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Misc write that leaves freeze clear, so it lands two edges on
  sequence s_wr_misc;
    reg_wr_i && reg_addr_i == 8'h08 && !reg_wdata_i[5];
  endsequence
  sequence s_stall;
    out_valid_o && !out_ready_i;
  endsequence
  chk_unmapped_read: assert property (!($past(reg_addr_i) inside {[8'h07:8'h09]}) |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_ramp_reserved: assert property ($past(reg_addr_i) == 8'h07 |-> (reg_rdata_o & 8'h0A) == 8'h00)
    else $error("reserved ramp bits set");
  chk_misc_reserved: assert property ($past(reg_addr_i) == 8'h08 |-> reg_rdata_o[2:0] == 3'h0)
    else $error("reserved misc bits set");
  chk_misc_apply: assert property (s_wr_misc |-> ##2 register_mode_enable_o == $past(reg_wdata_i[6], 2)
    && power_down_o == ($past(reg_wdata_i[7], 2) && $past(reg_wdata_i[6], 2)))
    else $error("misc write not applied");
  // Gain output is registered, so it shows silence one edge after the mute pin rises
  chk_mute_a_full: assert property (mute_control_out_o[0] && !bitstream_atten_o[0] &&
    !direct_bitstream_path_o |=> gain_level_o[9:0] == 10'h3FC)
    else $error("mute a before full attenuation");
  chk_mute_b_full: assert property (mute_control_out_o[1] && !bitstream_atten_o[1] &&
    !direct_bitstream_path_o |=> gain_level_o[19:10] == 10'h3FC)
    else $error("mute b before full attenuation");
  chk_gain_range: assert property (gain_level_o[9:0] <= 10'h3FC && gain_level_o[19:10] <= 10'h3FC)
    else $error("gain beyond full attenuation");
  chk_down_ready: assert property (power_down_o |-> !smp_ready_o && register_mode_enable_o)
    else $error("power down not honoured");
  chk_out_hold: assert property (s_stall |=> out_valid_o && $stable(out_data_o))
    else $error("output word dropped in stall");
endmodule // drc_ramp_ctrl_props
bind drc_ramp_ctrl drc_ramp_ctrl_props i_drc_ramp_ctrl_props (.*);
`default_nettype wire

// ### testbench/drc_ramp_ctrl_tb_top.sv
// Self-checking bench for the control block
`timescale 1ns/10ps
`default_nettype none
module drc_ramp_ctrl_tb_top;
  logic clk_sys_i = 0, rst_n_i = 0, reg_wr_i = 0, bitstream_mode_i = 0, ratio_error_i = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [15:0] attenuation_code_i = 16'h0000;
  logic [1:0] chan_mute_i = 0, deemphasis_select_i = 0, hold = 0, bitstream_bit_i, mute_control_out_o;
  logic [1:0] bitstream_atten_o;
  logic bitstream_auto_mute_i = 1, frame_clock_i, bitstream_serial_clock_i, smp_valid_i, smp_ready_o;
  logic out_valid_o, out_ready_i, conv_suspend_o, interp_rolloff_select_o, direct_bitstream_path_o;
  logic phase_mod_enable_o, phase_mod_clock_select_o, power_down_o, register_mode_enable_o, clk_en_o;
  logic stall = 0, is_static = 0;
  logic [47:0] smp_data_i, out_data_o;
  logic [47:0] sent[$];
  logic [19:0] gain_level_o;
  int bad_count = 0, checked = 0, seed = 32'h938F90F9;
  drc_ramp_ctrl i_drc_ramp_ctrl (.*);
  drc_src_model i_drc_src_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pm_sel_i(phase_mod_clock_select_o),
    .bs_run_i(bitstream_mode_i), .static_i(is_static), .hold_i(hold), .stall_i(stall),
    .smp_ready_i(smp_ready_o), .frame_o(frame_clock_i), .bs_clk_o(bitstream_serial_clock_i),
    .bs_bit_o(bitstream_bit_i), .smp_valid_o(smp_valid_i), .smp_data_o(smp_data_i), .out_ready_o(out_ready_i));
  always #10 clk_sys_i = ~clk_sys_i;
  task automatic check(input logic [47:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d of %0d checks", bad_count, checked);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [19:0] gl(input logic [15:0] c);
    return {c[15:8], 2'b00, c[7:0], 2'b00};
  endfunction
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(negedge clk_sys_i);
    reg_wr_i = 0;
    @(negedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    @(negedge clk_sys_i);
    check(reg_rdata_o, exp);
  endtask
  // Frames counted until the level lands; bounded so a stuck ramp ends
  task automatic wait_gain(input logic [19:0] exp, input int lim, output int n);
    n = 0;
    while (gain_level_o !== exp && n < lim) begin
      @(posedge frame_clock_i);
      n++;
    end
  endtask
  // Random stall of the sink, drawn on the rising edge to keep clear of the stimulus
  always @(posedge clk_sys_i) stall <= $random(seed) % 2;
  // Every word leaving the buffer must be the oldest one accepted
  always @(posedge clk_sys_i) begin
    if (smp_valid_i && smp_ready_o) sent.push_back(smp_data_i);
    if (out_valid_o && out_ready_i) check(out_data_o, sent.pop_front());
  end
  initial begin
    // Roughly 80k cycles, well past the longest timeout wait
    #1600000;
    bad_count++;
    end_sim();
  end
  initial begin
    int n;
    logic [15:0] c;
    repeat (5) @(negedge clk_sys_i);
    rst_n_i = 1;
    rd(8'h07, 8'hB0);
    rd(8'h08, 8'h80);
    rd(8'h09, 8'h08);
    rd(8'h0A, 8'h00);
    check(power_down_o, 1'b0);
    wr(8'h07, 8'h0A);
    rd(8'h07, 8'h00);
    wr(8'h08, 8'hC0);
    check({power_down_o, smp_ready_o}, 2'b10);
    wr(8'h08, 8'h40);
    check({register_mode_enable_o, power_down_o}, 2'b10);
    // Immediate policy: random codes land in one step
    for (int i = 0; i < 4; i++) begin
      c = $random(seed);
      attenuation_code_i = (i == 0) ? 16'hFF00 : c;
      repeat (3) @(negedge clk_sys_i);
      check(gain_level_o, gl(attenuation_code_i));
    end
    attenuation_code_i = 16'h1010;
    repeat (3) @(negedge clk_sys_i);
    // Soft ramp: two codes are eight eighth-dB steps, one per frame
    wr(8'h07, 8'h80);
    attenuation_code_i = 16'h1210;
    wait_gain(gl(16'h1210), 40, n);
    check(n >= 8 && n <= 10, 1'b1);
    // Zero cross: channel A never crosses, so only its timeout moves it
    hold = 2'b01;
    // Let held samples pass first so an old sign cannot count as a crossing
    repeat (3) @(posedge frame_clock_i);
    wr(8'h07, 8'h40);
    attenuation_code_i = 16'h2020;
    repeat (4) @(posedge frame_clock_i);
    check(gain_level_o[19:10], 10'h080);
    check(gain_level_o[9:0], 10'h040);
    wait_gain(gl(16'h2020), 1100, n);
    check(n >= 500 && n <= 1024, 1'b1);
    hold = 2'b00;
    wr(8'h07, 8'h00);
    chan_mute_i = 2'b01;
    repeat (3) @(negedge clk_sys_i);
    check({mute_control_out_o, gain_level_o[9:0]}, {2'b01, 10'h3FC});
    chan_mute_i = 2'b00;
    // Ratio error drops to silence, then unmutes at once or by ramp
    for (int u = 0; u < 2; u++) begin
      wr(8'h07, u ? 8'hA0 : 8'h80);
      ratio_error_i = 1;
      @(negedge clk_sys_i);
      ratio_error_i = 0;
      repeat (2) @(negedge clk_sys_i);
      check(gain_level_o, 20'hFF3FC);
      @(negedge clk_sys_i);
      check(u ? gain_level_o[9:0] >= 10'h3FB : gain_level_o == gl(16'h2020), 1'b1);
    end
    wr(8'h07, 8'h00);
    repeat (3) @(negedge clk_sys_i);
    // Freeze holds the rolloff change until released
    wr(8'h08, 8'h60);
    wr(8'h07, 8'h04);
    check(interp_rolloff_select_o, 1'b0);
    wr(8'h08, 8'h40);
    check(interp_rolloff_select_o, 1'b1);
    n = 0;
    while (!conv_suspend_o && n < 200) begin
      @(negedge clk_sys_i);
      n++;
    end
    check(conv_suspend_o, 1'b1);
    @(negedge clk_sys_i);
    check(gain_level_o, 20'hFF3FC);
    repeat (18) @(posedge frame_clock_i);
    check({conv_suspend_o, gain_level_o}, {1'b0, gl(16'h2020)});
    wr(8'h09, 8'h0B);
    check({phase_mod_enable_o, phase_mod_clock_select_o}, 2'b11);
    bitstream_mode_i = 1;
    repeat (100) @(negedge clk_sys_i);
    check(bitstream_atten_o, 2'b00);
    is_static = 1;
    repeat (100) @(negedge clk_sys_i);
    check(bitstream_atten_o, 2'b11);
    // Direct path and the majority watchdog on a static stream
    wr(8'h07, 8'h05);
    wr(8'h09, 8'h07);
    repeat (10) @(negedge clk_sys_i);
    check({direct_bitstream_path_o, gain_level_o, bitstream_atten_o}, 23'h400003);
    wr(8'h09, 8'h03);
    repeat (10) @(negedge clk_sys_i);
    check(bitstream_atten_o, 2'b00);
    // Divided enables: one pulse in three, then one in two
    for (int d = 0; d < 2; d++) begin
      wr(8'h08, d ? 8'h50 : 8'h48);
      n = 0;
      repeat (30) begin
        @(negedge clk_sys_i);
        n += clk_en_o;
      end
      check(n, d ? 15 : 10);
    end
    end_sim();
  end
endmodule // drc_ramp_ctrl_tb_top
`default_nettype wire

// ### testbench/drc_src_model.sv
// Audio source and sink model facing the control block
`timescale 1ns/10ps
`default_nettype none
module drc_src_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic pm_sel_i,
  input wire logic bs_run_i,
  input wire logic static_i,
  input wire logic [1:0] hold_i,
  input wire logic stall_i,
  input wire logic smp_ready_i,
  output logic frame_o,
  output logic bs_clk_o,
  output logic [1:0] bs_bit_o,
  output logic smp_valid_o,
  output logic [47:0] smp_data_o,
  output logic out_ready_o
);
  logic [31:0] cyc;
  logic [7:0] k;
  logic took;
  // Handshake seen at the sampling edge, acted on at the next fall
  always @(posedge clk_sys_i) took <= smp_valid_o && smp_ready_i;
  // Held channel keeps one sign, so it never crosses zero
  always @(negedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {cyc, k, frame_o, bs_clk_o, bs_bit_o, smp_valid_o, out_ready_o} <= '0;
      smp_data_o <= 48'h0;
    end else begin
      cyc <= cyc + 1;
      frame_o <= cyc[4:0] == 5'h00;
      bs_clk_o <= bs_run_i && (pm_sel_i ? cyc[0] : 1'b1);
      if (bs_clk_o) bs_bit_o <= static_i ? 2'b11 : ~bs_bit_o;
      out_ready_o <= !stall_i;
      if (took) begin
        smp_valid_o <= 1'b0;
        smp_data_o <= ~smp_data_o;
      end
      if (cyc[4:0] == 5'h00 && (!smp_valid_o || took)) begin
        smp_valid_o <= 1'b1;
        k <= k + 1;
        smp_data_o <= {(hold_i[1] | k[0]) ? 16'h0001 : 16'hFF00, k, (hold_i[0] | k[0]) ? 16'h0001 : 16'hFF00, k};
      end
    end
  end
endmodule // drc_src_model
`default_nettype wire
